// >>> design/halt_power_mode_control.sv
// Halt power-mode control: picks timed sleep or plain halt on a halt
// instruction, gates clocks, and handles wake-up by interrupt or reset.
// Assumes the core presents its fetched opcode with a valid strobe and
// that wake sources are pins or other domains, so they are synchronised.
//
// Notes on behaviour
// - Opcode 0x8E requests a low-power state.
// - Timer enable bits choose timed sleep, else halt.
// - Timed sleep exits only on wake interrupt, reset.
// - Reset wake waits 256 cycles, then reset vector.
// - Interrupt wake resumes at once, no delay.
// - Entry clears interrupt mask; pending interrupt wakes.
// - Timed sleep clocks only oscillator and timer.
// - Watchdog reset suppressed when halting into sleep.
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module halt_power_mode_control (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clkEnable,
   input wire logic [7:0] opcode,
   input wire logic opcodeValid,
   input wire logic irqMaskIn,
   input wire halt_power_pkg::wake_sources_t wakeIn,
   input wire logic watchdogTimeout,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regReadData,
   output logic irqMaskClear,
   output halt_power_pkg::clock_gates_t clockGates,
   output logic coreResume,
   output logic fetchResetVector,
   output logic serviceIrqVector,
   output logic watchdogReset
);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   halt_power_pkg::wake_sources_t wakeMeta; // First stage, read by second.
   halt_power_pkg::wake_sources_t wakeSync; // Safe to use in logic.
   logic wdogMeta; // First stage of the watchdog timeout.
   logic wdogSync; // Synchronised watchdog timeout.

   // Two flip-flops per asynchronous input before any logic reads it.
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         wakeMeta <= '0;
         wakeSync <= '0;
         wdogMeta <= 1'b0;
         wdogSync <= 1'b0;
      end
      else if (clkEnable)
      begin
         wakeMeta <= wakeIn;
         wakeSync <= wakeMeta;
         wdogMeta <= watchdogTimeout;
         wdogSync <= wdogMeta;
      end
   end

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   logic [7:0] wakeConfig; // Timer enable and clock select bits.
   logic [7:0] next_wakeConfig; // Next configuration value.
   logic [7:0] next_regReadData; // Next read data.
   halt_power_pkg::power_state_t state; // Current power state.
   halt_power_pkg::power_state_t next_state; // Next power state.

   // True when the timer bits select timed sleep on a halt.
   function automatic logic sleepEnabled(input logic [7:0] cfg);
      sleepEnabled = cfg[halt_power_pkg::CFG_LITE_TB_IE] |
         (cfg[halt_power_pkg::CFG_AT_OVF_IE] &
          ~cfg[halt_power_pkg::CFG_AT_CK1] &
          cfg[halt_power_pkg::CFG_AT_CK0]);
   endfunction : sleepEnabled

   // Writes update the configuration; reads answer one cycle later.
   always_comb
   begin
      next_wakeConfig = wakeConfig;
      next_regReadData = 8'h00;
      if (regWrite && regAddr == halt_power_pkg::ADDR_CONFIG)
      begin
         // Only the four defined bits are kept; the rest read zero.
         next_wakeConfig = {4'h0, regWriteData[3:0]};
      end
      if (regRead)
      begin
         case (regAddr)
            halt_power_pkg::ADDR_CONFIG: next_regReadData = wakeConfig;
            halt_power_pkg::ADDR_STATUS:
               next_regReadData = {5'h00, sleepEnabled(wakeConfig),
                  2'(state)};
            // Unmapped addresses read as zero.
            default: next_regReadData = 8'h00;
         endcase
      end
   end

   // Register the configuration and the read data.
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         wakeConfig <= halt_power_pkg::CONFIG_RESET;
         regReadData <= 8'h00;
      end
      else if (clkEnable)
      begin
         wakeConfig <= next_wakeConfig;
         regReadData <= next_regReadData;
      end
   end

   // ------------------------------------------------------------
   // Power state machine
   // ------------------------------------------------------------
   logic delayStart; // Starts the reset wake-up delay.
   logic delayDone; // Delay has elapsed.
   logic haltReq; // Halt instruction seen.
   logic next_irqMaskClear; // Next mask-clear pulse.
   halt_power_pkg::clock_gates_t next_clockGates; // Next clock gates.
   logic next_coreResume; // Next resume pulse.
   logic next_fetchResetVector; // Next reset vector pulse.
   logic next_serviceIrqVector; // Next interrupt vector pulse.
   logic next_watchdogReset; // Next watchdog reset level.

   assign haltReq = opcodeValid &&
      opcode == halt_power_pkg::HALT_OPCODE;

   wake_delay_counter #(
      .WIDTH(9)
   ) u_delay (
      .ref_clk(ref_clk),
      .reset(reset),
      .clkEnable(clkEnable),
      .start(delayStart),
      .load(halt_power_pkg::RESET_WAKE_DELAY),
      .done(delayDone)
   );

   // Next state and outputs. Wake sources are sampled after the
   // synchronisers, so a pending interrupt wakes within three cycles.
   always_comb
   begin
      next_state = state;
      delayStart = 1'b0;
      next_irqMaskClear = 1'b0;
      next_coreResume = 1'b0;
      next_fetchResetVector = 1'b0;
      next_serviceIrqVector = 1'b0;
      next_watchdogReset = 1'b0;
      next_clockGates = '{mainOsc: 1'b1, wakeTimer: 1'b1,
         peripherals: 1'b1, core: 1'b1};
      case (state)
         halt_power_pkg::RUN:
         begin
            // A watchdog timeout in normal run still resets the part.
            next_watchdogReset = wdogSync && !haltReq;
            if (haltReq)
            begin
               next_irqMaskClear = 1'b1;
               if (sleepEnabled(wakeConfig))
               begin
                  next_state = halt_power_pkg::TIMED_SLEEP;
               end
               else
               begin
                  next_state = halt_power_pkg::PLAIN_HALT;
               end
            end
         end
         halt_power_pkg::TIMED_SLEEP:
         begin
            // Keep the time base alive, gate everything else.
            next_clockGates = '{mainOsc: 1'b1, wakeTimer: 1'b1,
               peripherals: 1'b0, core: 1'b0};
            // The watchdog cannot reset the part from here.
            next_watchdogReset = 1'b0;
            if (wakeSync.resetReq)
            begin
               delayStart = 1'b1;
               next_state = halt_power_pkg::WAKE_DELAY;
            end
            else if (wakeSync.timerIrq || wakeSync.externalIrq)
            begin
               // The core must have its clock in the very cycle that it
               // is told to resume, or the resume would be lost.
               next_clockGates = '{mainOsc: 1'b1, wakeTimer: 1'b1,
                  peripherals: 1'b1, core: 1'b1};
               next_coreResume = 1'b1;
               next_serviceIrqVector = 1'b1;
               next_state = halt_power_pkg::RUN;
            end
            else
            begin
               next_state = halt_power_pkg::TIMED_SLEEP;
            end
         end
         halt_power_pkg::PLAIN_HALT:
         begin
            next_clockGates = '{mainOsc: 1'b0, wakeTimer: 1'b0,
               peripherals: 1'b0, core: 1'b0};
            if (wakeSync.resetReq)
            begin
               delayStart = 1'b1;
               next_state = halt_power_pkg::WAKE_DELAY;
            end
            else if (wakeSync.externalIrq)
            begin
               // All clocks return together with the resume pulse.
               next_clockGates = '{mainOsc: 1'b1, wakeTimer: 1'b1,
                  peripherals: 1'b1, core: 1'b1};
               next_coreResume = 1'b1;
               next_serviceIrqVector = 1'b1;
               next_state = halt_power_pkg::RUN;
            end
         end
         halt_power_pkg::WAKE_DELAY:
         begin
            // Oscillator runs but the core waits out the delay.
            next_clockGates = '{mainOsc: 1'b1, wakeTimer: 1'b0,
               peripherals: 1'b0, core: 1'b0};
            if (delayDone)
            begin
               next_coreResume = 1'b1;
               next_fetchResetVector = 1'b1;
               next_state = halt_power_pkg::RUN;
            end
         end
         default:
         begin
            next_state = halt_power_pkg::RUN;
         end
      endcase
   end

   // State and output registers; every output leaves a flip-flop.
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state <= halt_power_pkg::RUN;
         irqMaskClear <= 1'b0;
         clockGates <= '1;
         coreResume <= 1'b0;
         fetchResetVector <= 1'b0;
         serviceIrqVector <= 1'b0;
         watchdogReset <= 1'b0;
      end
      else if (clkEnable)
      begin
         state <= next_state;
         irqMaskClear <= next_irqMaskClear;
         clockGates <= next_clockGates;
         coreResume <= next_coreResume;
         fetchResetVector <= next_fetchResetVector;
         serviceIrqVector <= next_serviceIrqVector;
         watchdogReset <= next_watchdogReset;
      end
   end

   // The incoming mask level is informational; the core owns it.
   logic unusedMask; // Keeps the mask input read.
   assign unusedMask = irqMaskIn;

endmodule : halt_power_mode_control
`default_nettype wire

// >>> design/halt_power_pkg.sv
// Constants and carrier types for the halt power-mode control.
// Assumes a single core clock domain and a synchronous active-high reset.
package halt_power_pkg;

   // ------------------------------------------------------------
   // Opcodes and counts
   // ------------------------------------------------------------
   localparam logic [7:0] HALT_OPCODE = 8'h8E; // Halt instruction code.
   localparam int RESET_WAKE_DELAY_CYCLES = 256; // Start-up delay length.
   localparam logic [8:0] RESET_WAKE_DELAY = 9'h100; // Same count, sized.

   // ------------------------------------------------------------
   // Register bus map and field positions
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_CONFIG = 4'h0; // Wake configuration bits.
   localparam logic [3:0] ADDR_STATUS = 4'h1; // Mode and state readback.
   localparam int CFG_LITE_TB_IE = 0; // Lite timer time-base enable.
   localparam int CFG_AT_OVF_IE = 1; // Auto timer overflow enable.
   localparam int CFG_AT_CK0 = 2; // Auto timer clock select, low bit.
   localparam int CFG_AT_CK1 = 3; // Auto timer clock select, high bit.
   localparam logic [7:0] CONFIG_RESET = 8'h00; // Value after reset.

   // Power state of the core.
   typedef enum logic [1:0] {RUN, TIMED_SLEEP, PLAIN_HALT, WAKE_DELAY}
      power_state_t;

   // Clock gate bundle handed to the clock tree.
   typedef struct packed {
      logic mainOsc; // Main oscillator runs.
      logic wakeTimer; // Selected wake timer counter is clocked.
      logic peripherals; // Ordinary peripherals are clocked.
      logic core; // Core clock runs.
   } clock_gates_t;

   // Wake-up request bundle from the interrupt and reset logic.
   typedef struct packed {
      logic timerIrq; // Wake-capable timer interrupt is pending.
      logic externalIrq; // External interrupt is pending.
      logic resetReq; // A reset source asks for a restart.
   } wake_sources_t;

endpackage : halt_power_pkg

// >>> design/wake_delay_counter.sv
// Down counter that times the start-up delay after a reset wake-up.
// Assumes the enclosing block gives it the core clock and its enable.
`timescale 1ns/1ps
`default_nettype none
module wake_delay_counter #(
   parameter int WIDTH = 9
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clkEnable,
   input wire logic start,
   input wire logic [WIDTH-1:0] load,
   output logic done
);

   // ------------------------------------------------------------
   // Counter state
   // ------------------------------------------------------------
   logic [WIDTH-1:0] count; // Cycles still to wait.
   logic [WIDTH-1:0] next_count; // Next value of the counter.
   logic running; // Counter is active.
   logic next_running; // Next value of running.
   logic next_done; // Next value of done.

   // Load on start, then count down; done pulses on the last cycle.
   always_comb
   begin
      next_count = count;
      next_running = running;
      next_done = 1'b0;
      if (start)
      begin
         next_count = load - {{(WIDTH-1){1'b0}}, 1'b1};
         next_running = 1'b1;
      end
      else if (running)
      begin
         // A count that reaches zero ends the wait on this edge.
         if (count == '0)
         begin
            next_running = 1'b0;
            next_done = 1'b1;
         end
         else
         begin
            next_count = count - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

   // Registers only; the enable freezes the whole counter.
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         count <= '0;
         running <= 1'b0;
         done <= 1'b0;
      end
      else if (clkEnable)
      begin
         count <= next_count;
         running <= next_running;
         done <= next_done;
      end
   end

endmodule : wake_delay_counter
`default_nettype wire

// >>> dv/core_model.sv
// Core model: fetches one opcode per request and counts wake-ups.
// Assumes the bench raises issue for one cycle at a time.
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic issue,
   input wire logic [7:0] code,
   input wire logic coreResume,
   output logic [7:0] opcode,
   output logic opcodeValid,
   output logic [7:0] resumes
);
   // Idle opcode shows the inverse so a stale halt code never lingers.
   always_ff @(posedge ref_clk)
   begin
      opcodeValid <= issue & ~reset;
      opcode <= issue ? code : ~code;
      if (reset)
         resumes <= 8'h00;
      else if (coreResume)
         resumes <= resumes + 8'h01;
   end
endmodule : core_model
`default_nettype wire

// >>> dv/halt_power_checker.sv
// Port checker for the halt power-mode control.
// Assumes it is bound to the top module and clkEnable is held high.
`timescale 1ns/1ps
`default_nettype none
module halt_power_checker (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] opcode,
   input wire logic opcodeValid,
   input wire halt_power_pkg::wake_sources_t wakeIn,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regReadData,
   input wire logic irqMaskClear,
   input wire halt_power_pkg::clock_gates_t clockGates,
   input wire logic coreResume,
   input wire logic fetchResetVector,
   input wire logic serviceIrqVector,
   input wire logic watchdogReset
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   logic [3:0] cfg; // Shadow of the wake configuration bits.
   logic [9:0] delayCnt; // Cycles with only the oscillator running.
   logic sleepOn; // Timed sleep is selected by the shadow bits.
   assign sleepOn = cfg[0] | (cfg[1] & ~cfg[3] & cfg[2]);
   // The shadow lets mode checks stand without peeking into the design.
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         cfg <= 4'h0;
      else if (regWrite && regAddr == 4'h0)
         cfg <= regWriteData[3:0];
      if (reset || clockGates != 4'h8)
         delayCnt <= 10'h000;
      else
         delayCnt <= delayCnt + 10'h001;
   end
   sequence s_halt;
      opcodeValid && opcode == halt_power_pkg::HALT_OPCODE;
   endsequence
   sequence s_quiet;
      clockGates == 4'h0 && !wakeIn.externalIrq && !wakeIn.resetReq;
   endsequence
   property p_mask;
      irqMaskClear |-> $past(opcodeValid) &&
         $past(opcode) == halt_power_pkg::HALT_OPCODE;
   endproperty
   property p_mode;
      s_halt ##1 irqMaskClear |=> serviceIrqVector ||
         clockGates == (sleepOn ? 4'hC : 4'h0);
   endproperty
   property p_resume;
      (coreResume || serviceIrqVector || fetchResetVector) |->
         coreResume && (serviceIrqVector != fetchResetVector);
   endproperty
   property p_irqGates;
      serviceIrqVector |-> clockGates == 4'hF;
   endproperty
   property p_delay;
      fetchResetVector |-> delayCnt >= 10'd255 && delayCnt <= 10'd260;
   endproperty
   property p_sleepHold;
      (clockGates == 4'hC) ##1 (clockGates != 4'hC) |->
         (|$past(wakeIn, 3)) || (|$past(wakeIn, 4));
   endproperty
   property p_haltHold;
      s_quiet [*4] |=> clockGates == 4'h0;
   endproperty
   property p_wdog;
      watchdogReset |-> clockGates == 4'hF && !irqMaskClear;
   endproperty
   property p_read;
      !(regRead && regAddr <= 4'h1) |=> regReadData == 8'h00;
   endproperty
   a_mask: assert property (p_mask) else $error("mask clear bad");
   a_mode: assert property (p_mode) else $error("mode gates bad");
   a_resume: assert property (p_resume) else $error("resume bad");
   a_irqGates: assert property (p_irqGates) else $error("irq gates");
   a_delay: assert property (p_delay) else $error("reset delay");
   a_sleepHold: assert property (p_sleepHold) else $error("sleep");
   a_haltHold: assert property (p_haltHold) else $error("halt");
   a_wdog: assert property (p_wdog) else $error("watchdog");
   a_read: assert property (p_read) else $error("read data");
endmodule : halt_power_checker
`default_nettype wire

// >>> dv/tb_top.sv
// Bench: table rows of configurations, then reset and edge cases.
// Assumes the core model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct packed {
      logic [7:0] cfg;
      logic [2:0] wake;
      logic [3:0] gates;
   } row_t;
   // Wake is {timer, external, reset}; sleep gates 4'hC, halt 4'h0.
   row_t rows [7] = '{'{8'h01, 3'h4, 4'hC}, '{8'h06, 3'h4, 4'hC},
      '{8'hF1, 3'h2, 4'hC}, '{8'h0E, 3'h2, 4'h0}, '{8'h02, 3'h2, 4'h0},
      '{8'h04, 3'h2, 4'h0}, '{8'h00, 3'h2, 4'h0}};
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic issue = 1'b0;
   logic [7:0] code = halt_power_pkg::HALT_OPCODE;
   halt_power_pkg::wake_sources_t wakeIn = 3'h0;
   logic watchdogTimeout = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWriteData = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] opcode, regReadData, resumes, d;
   logic opcodeValid, irqMaskClear, coreResume;
   logic fetchResetVector, serviceIrqVector, watchdogReset;
   halt_power_pkg::clock_gates_t clockGates;
   int n_errors = 0;
   int total_checks = 0;
   int n;
   always #50 ref_clk = ~ref_clk;
   core_model core_model_inst (.ref_clk(ref_clk), .reset(reset),
      .issue(issue), .code(code), .coreResume(coreResume),
      .opcode(opcode), .opcodeValid(opcodeValid), .resumes(resumes));
   halt_power_mode_control halt_power_mode_control_inst (
      .ref_clk(ref_clk), .reset(reset), .clkEnable(1'b1),
      .opcode(opcode), .opcodeValid(opcodeValid), .irqMaskIn(1'b0),
      .wakeIn(wakeIn), .watchdogTimeout(watchdogTimeout),
      .regAddr(regAddr), .regWriteData(regWriteData),
      .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
      .irqMaskClear(irqMaskClear), .clockGates(clockGates),
      .coreResume(coreResume), .fetchResetVector(fetchResetVector),
      .serviceIrqVector(serviceIrqVector), .watchdogReset(watchdogReset));
   task chk_v(input string what, input logic [7:0] exp, got);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_v
   task chk_b(input string what, input logic exp, got);
      chk_v(what, {7'h00, exp}, {7'h00, got});
   endtask : chk_b
   task wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      regAddr <= a;
      regWriteData <= v;
      regWrite <= 1'b1;
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge ref_clk);
      regRead <= 1'b0;
      #1;
      v = regReadData;
   endtask : rd
   // Fetch one opcode; a halt must answer with a mask-clear pulse.
   task fetch(input logic isHalt);
      @(posedge ref_clk);
      issue <= 1'b1;
      @(posedge ref_clk);
      issue <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk_b("mask clear", isHalt, irqMaskClear);
      @(posedge ref_clk);
      #1;
   endtask : fetch
   task wt(input logic rst, input int lim, output int k);
      k = 0;
      while ((rst ? fetchResetVector : serviceIrqVector) !== 1'b1 && k < lim)
      begin
         @(posedge ref_clk);
         #1;
         k++;
      end
   endtask : wt
   task gates(input string what, input logic [3:0] exp);
      chk_v(what, {4'h0, exp}, {4'h0, clockGates});
   endtask : gates
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   // A hang past a generous bound ends the run as failed.
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      end_sim();
   end
   initial
   begin
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      #1;
      gates("reset gates", 4'hF);
      foreach (rows[i])
      begin
         wr(4'h0, rows[i].cfg);
         rd(4'h0, d);
         chk_v("config", {4'h0, rows[i].cfg[3:0]}, d);
         fetch(1'b1);
         gates("mode gates", rows[i].gates);
         repeat (6) @(posedge ref_clk);
         #1;
         gates("held gates", rows[i].gates);
         @(posedge ref_clk);
         wakeIn <= rows[i].wake;
         wt(1'b0, 12, n);
         chk_b("irq wake", 1'b1, serviceIrqVector);
         chk_b("prompt", 1'b1, n <= 5);
         gates("run gates", 4'hF);
         @(posedge ref_clk);
         wakeIn <= 3'h0;
         $display("test row %0d done", i);
      end
      wr(4'h0, 8'h00);
      wakeIn <= 3'h4;
      fetch(1'b1);
      wt(1'b0, 20, n);
      gates("halt gates", 4'h0);
      rd(4'h1, d);
      chk_v("status", 8'h02, d);
      rd(4'h7, d);
      chk_v("unmapped", 8'h00, d);
      wakeIn <= 3'h6;
      wt(1'b0, 12, n);
      chk_b("ext wake", 1'b1, serviceIrqVector);
      $display("test plain halt done");
      wr(4'h0, 8'h01);
      wakeIn <= 3'h0;
      watchdogTimeout <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      chk_b("watchdog", 1'b1, watchdogReset);
      fetch(1'b1);
      repeat (3) @(posedge ref_clk);
      #1;
      chk_b("no watchdog", 1'b0, watchdogReset);
      gates("sleep gates", 4'hC);
      rd(4'h1, d);
      chk_v("sleep status", 8'h05, d);
      wakeIn <= 3'h4;
      watchdogTimeout <= 1'b0;
      wt(1'b0, 12, n);
      fetch(1'b1);
      wt(1'b0, 4, n);
      chk_b("pending wake", 1'b1, serviceIrqVector);
      $display("test watchdog and pending done");
      wakeIn <= 3'h0;
      repeat (4) @(posedge ref_clk);
      fetch(1'b1);
      wakeIn <= 3'h1;
      repeat (5) @(posedge ref_clk);
      wakeIn <= 3'h0;
      wt(1'b1, 400, n);
      chk_b("reset wake", 1'b1, fetchResetVector);
      chk_b("delay", 1'b1, n + 5 >= 256 && n + 5 <= 264);
      $display("test reset wake done");
      code <= 8'h8F;
      fetch(1'b0);
      repeat (4) @(posedge ref_clk);
      #1;
      gates("other opcode", 4'hF);
      chk_v("resumes", 8'h0B, resumes);
      code <= halt_power_pkg::HALT_OPCODE;
      fetch(1'b1);
      reset <= 1'b1;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      #1;
      gates("mid reset", 4'hF);
      rd(4'h0, d);
      chk_v("reset config", 8'h00, d);
      $display("test mid reset done");
      end_sim();
   end
endmodule : tb_top
bind halt_power_mode_control halt_power_checker checker_inst (
   .ref_clk(ref_clk), .reset(reset), .opcode(opcode),
   .opcodeValid(opcodeValid), .wakeIn(wakeIn), .regAddr(regAddr),
   .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
   .regReadData(regReadData), .irqMaskClear(irqMaskClear),
   .clockGates(clockGates), .coreResume(coreResume),
   .fetchResetVector(fetchResetVector),
   .serviceIrqVector(serviceIrqVector), .watchdogReset(watchdogReset));
`default_nettype wire
